// File: pkg/bsw_pkg.sv
package bsw_pkg;
  // ==========================================================
  // register offsets (byte offsets within config space)
  localparam logic [7:0] OFF_LAT_TIMER  = 8'h1B;
  localparam logic [7:0] OFF_IO_BASE    = 8'h1C;
  localparam logic [7:0] OFF_IO_LIMIT   = 8'h1D;
  localparam logic [7:0] OFF_SEC_STATUS = 8'h1E;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h40;
  localparam logic [7:0] OFF_IO_ADDR    = 8'h44;

  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_LAT_TIMER  = 8'h00;
  localparam logic [7:0]  RST_IO_BASE    = 8'hF0;
  localparam logic [7:0]  RST_IO_LIMIT   = 8'h00;
  localparam logic [15:0] RST_SEC_STATUS = 16'h02A0;

  // ==========================================================
  // field positions
  localparam int LAT_LSB        = 3;
  localparam int LAT_W          = 5;
  localparam int IOF_LSB        = 4;
  localparam int IOF_W          = 4;
  localparam int ST_PARITY      = 15;
  localparam int ST_SYSERR      = 14;
  localparam int ST_MABORT      = 13;
  localparam int ST_TABORT_RX   = 12;
  localparam int ST_TABORT_TX   = 11;
  localparam int ST_SEL_LSB     = 9;
  localparam int ST_MPAR        = 8;
  localparam int ST_B2B         = 7;
  localparam int ST_HS          = 5;
  localparam logic [1:0]  SEL_TIMING_MED = 2'h1;
  localparam logic [15:0] W1C_MASK       = 16'hB000;
  localparam logic [11:0] IO_LOW_ONES    = 12'hFFF;
  localparam logic [11:0] IO_LOW_ZERO    = 12'h000;

  typedef struct packed {
    logic parity;
    logic mabort;
    logic tabort;
  } bsw_evt_t;

  typedef enum logic [1:0] {
    TEN_IDLE   = 2'b00,
    TEN_OWN    = 2'b01,
    TEN_EXPIRE = 2'b11
  } bsw_ten_t;
endpackage

// File: rtl/bsw_io_window.sv
`timescale 1ns/1ps
module bsw_io_window (
  input  wire logic [bsw_pkg::IOF_W-1:0] base_i,
  input  wire logic [bsw_pkg::IOF_W-1:0] limit_i,
  input  wire logic [15:0]               addr_i,
  output logic                           hit_o
);
  import bsw_pkg::*;
  logic [15:0] lo;
  logic [15:0] hi;
  assign lo    = {base_i, IO_LOW_ZERO};  // [RULE3]
  assign hi    = {limit_i, IO_LOW_ONES}; // [RULE4]
  assign hit_o = (addr_i >= lo) && (addr_i <= hi); // [RULE2]
endmodule

// File: rtl/bsw_tenure.sv
`timescale 1ns/1ps
module bsw_tenure #(
  parameter int W = bsw_pkg::LAT_W
) (
  input  wire logic         CLK_SYS_I,
  input  wire logic         RESET_N_I,
  input  wire logic [W-1:0] limit_i,
  input  wire logic         own_i,
  input  wire logic         gnt_i,
  output logic              release_o,
  output logic              expired_o
);
  import bsw_pkg::*;
  // ==========================================================
  // master tenure counter
  // timer counts in units of 8 clocks, like the classic field
  logic [W+2:0] cnt_q;
  bsw_ten_t     st_q;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q  <= TEN_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        TEN_IDLE: begin
          cnt_q <= {limit_i, 3'h0};
          if (own_i && limit_i != '0) begin // [RULE16]
            st_q <= TEN_OWN;
          end
        end
        TEN_OWN: begin
          if (!own_i) begin
            st_q <= TEN_IDLE;
          end else if (cnt_q <= {{(W+2){1'b0}}, 1'b1}) begin
            st_q <= TEN_EXPIRE;
          end else begin
            cnt_q <= cnt_q - 1'b1; // [RULE16]
          end
        end
        TEN_EXPIRE: begin
          if (!own_i) begin
            st_q <= TEN_IDLE;
          end
        end
      endcase
    end
  end

  assign expired_o = (st_q == TEN_EXPIRE);
  // timer zero holds the tenure in TEN_IDLE, so no release until it is written nonzero; zeroing it mid-tenure leaves the loaded count running
  assign release_o = expired_o && !gnt_i && own_i; // [RULE16] [RULE1]
endmodule

// File: rtl/bsw_top.sv
// Functional notes
// [RULE1] latency field bits 7:3, zero disables
// [RULE2] forward I/O only inside base..limit
// [RULE3] base gives A15:12, low bits zero
// [RULE4] limit gives A15:12, low bits ones
// [RULE5] parity error sets status bit 15
// [RULE6] master abort sets status bit 13
// [RULE7] received target abort sets bit 12
// [RULE8] error flags clear on writing one
// [RULE9] bit 14 always reads zero
// [RULE10] bit 11 always reads zero
// [RULE11] bits 10:9 always read 01b
// [RULE12] bit 8 always reads zero
// [RULE13] bit 7 reads one, fast back-to-back
// [RULE14] bit 5 reads one, 66 MHz
// [RULE15] reserved read zero; write zero keeps flag
// [RULE16] expired timer plus lost grant releases bus
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module bsw_top (
  input  wire logic          CLK_SYS_I,
  input  wire logic          RESET_N_I,
  input  wire logic          WB_CYC_I,
  input  wire logic          WB_STB_I,
  input  wire logic          WB_WE_I,
  input  wire logic [7:0]    WB_ADR_I,
  input  wire logic [3:0]    WB_SEL_I,
  input  wire logic [31:0]   WB_DAT_I,
  output logic      [31:0]   WB_DAT_O,
  output logic               WB_ACK_O,
  input  wire logic [15:0]   IO_ADDR_I,
  input  wire logic          IO_REQ_I,
  output logic               IO_FWD_O,
  input  wire bsw_pkg::bsw_evt_t EVT_I,
  input  wire logic          MST_OWN_I,
  input  wire logic          MST_GNT_I,
  output logic               MST_RELEASE_O,
  output logic               IRQ_O
);
  import bsw_pkg::*;

  // ==========================================================
  // registers
  logic [LAT_W-1:0] lat_q;
  logic [IOF_W-1:0] base_q;
  logic [IOF_W-1:0] limit_q;
  bsw_evt_t         flag_q;
  bsw_evt_t         mask_q;
  logic             ack_q;
  logic [31:0]      rdat_q;
  logic [15:0]      last_io_q;
  logic             fwd_q;
  logic             hit;
  logic             expired;

  function automatic logic [15:0] status_word(bsw_evt_t f);
    logic [15:0] s;
    s = 16'h0000;                            // [RULE15]
    s[ST_PARITY]    = f.parity;
    s[ST_SYSERR]    = 1'b0;                  // [RULE9]
    s[ST_MABORT]    = f.mabort;
    s[ST_TABORT_RX] = f.tabort;
    s[ST_TABORT_TX] = 1'b0;                  // [RULE10]
    s[ST_SEL_LSB +: 2] = SEL_TIMING_MED;     // [RULE11]
    s[ST_MPAR]      = 1'b0;                  // [RULE12]
    s[ST_B2B]       = 1'b1;                  // [RULE13]
    s[ST_HS]        = 1'b1;                  // [RULE14]
    return s;
  endfunction

  function automatic bsw_evt_t pack_evt(logic [15:0] w);
    bsw_evt_t e;
    e.parity = w[ST_PARITY];
    e.mabort = w[ST_MABORT];
    e.tabort = w[ST_TABORT_RX];
    return e;
  endfunction

  // ==========================================================
  // wishbone decode
  // config offsets are byte addresses; word = adr[7:2], lanes picked by WB_SEL_I (adr[1:0] unused)
  logic        req;
  logic        wr;
  logic [5:0]  word;
  logic [31:0] wmask;
  assign req  = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr   = req && WB_WE_I;
  assign word = WB_ADR_I[7:2];
  always_comb begin
    wmask = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{WB_SEL_I[i]}};
    end
  end

  logic [31:0] wd;
  assign wd = WB_DAT_I & wmask;

  // ack one cycle after the strobe; released next cycle
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // ==========================================================
  // writable fields, reserved bits not stored
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lat_q   <= RST_LAT_TIMER[LAT_LSB +: LAT_W];
      base_q  <= RST_IO_BASE[IOF_LSB +: IOF_W];
      limit_q <= RST_IO_LIMIT[IOF_LSB +: IOF_W];
      mask_q  <= '0;
    end else if (wr) begin
      if (word == OFF_LAT_TIMER[7:2] && WB_SEL_I[3]) begin
        lat_q <= WB_DAT_I[24 + LAT_LSB +: LAT_W]; // [RULE1]
      end
      if (word == OFF_IO_BASE[7:2] && WB_SEL_I[0]) begin
        base_q <= WB_DAT_I[IOF_LSB +: IOF_W]; // [RULE3]
      end
      if (word == OFF_IO_BASE[7:2] && WB_SEL_I[1]) begin
        limit_q <= WB_DAT_I[8 + IOF_LSB +: IOF_W]; // [RULE4]
      end
      // mask sits in the upper half, lanes 3 and 2, like the status flags
      if (word == OFF_IRQ_MASK[7:2] && WB_SEL_I[3] && WB_SEL_I[2]) begin
        mask_q <= pack_evt(WB_DAT_I[31:16]);
      end
    end
  end

  // ==========================================================
  // sticky error flags: set wins over a same-cycle clear
  logic     st_wr;
  bsw_evt_t clr;
  assign st_wr = wr && word == OFF_IO_BASE[7:2];
  assign clr   = st_wr ? pack_evt(wd[31:16] & W1C_MASK) : '0; // [RULE15]

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      flag_q <= pack_evt(RST_SEC_STATUS);
    end else begin
      flag_q.parity <= EVT_I.parity | (flag_q.parity & ~clr.parity); // [RULE5] [RULE8]
      flag_q.mabort <= EVT_I.mabort | (flag_q.mabort & ~clr.mabort); // [RULE6] [RULE8]
      flag_q.tabort <= EVT_I.tabort | (flag_q.tabort & ~clr.tabort); // [RULE7] [RULE8]
    end
  end

  assign IRQ_O = |(flag_q & mask_q);

  // ==========================================================
  // read data
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !WB_WE_I) begin
      unique case (word)
        OFF_IO_BASE[7:2]: begin
          rdat_q <= {status_word(flag_q),
                     limit_q, 4'h0, base_q, 4'h0}; // [RULE15]
        end
        OFF_LAT_TIMER[7:2]: begin
          rdat_q <= {lat_q, 3'h0, 24'h000000};
        end
        OFF_IRQ_MASK[7:2]: begin
          rdat_q <= {status_word(mask_q) & W1C_MASK, 16'h0000};
        end
        OFF_IO_ADDR[7:2]: begin
          rdat_q <= {15'h0000, fwd_q, last_io_q};
        end
        default: begin
          rdat_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign WB_DAT_O = rdat_q;
  assign WB_ACK_O = ack_q;

  // ==========================================================
  // I/O forwarding decision
  bsw_io_window u_win (
    .base_i  (base_q),
    .limit_i (limit_q),
    .addr_i  (IO_ADDR_I),
    .hit_o   (hit)
  );

  // base above limit gives an empty window: nothing forwards
  assign IO_FWD_O = IO_REQ_I && hit; // [RULE2]

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      last_io_q <= 16'h0000;
      fwd_q     <= 1'b0;
    end else if (IO_REQ_I) begin
      last_io_q <= IO_ADDR_I;
      fwd_q     <= hit;
    end
  end

  // ==========================================================
  // secondary master tenure
  bsw_tenure #(.W(LAT_W)) u_ten (
    .CLK_SYS_I (CLK_SYS_I),
    .RESET_N_I (RESET_N_I),
    .limit_i   (lat_q),
    .own_i     (MST_OWN_I),
    .gnt_i     (MST_GNT_I),
    .release_o (MST_RELEASE_O),
    .expired_o (expired)
  );

  logic unused_expired;
  assign unused_expired = expired;
endmodule

// File: tb/bridge_secondary_io_window_status_tb_top.sv
`timescale 1ns/1ps
module bridge_secondary_io_window_status_tb_top;
  import bsw_pkg::*;
  typedef struct packed {
    logic [3:0]  b;
    logic [3:0]  l;
    logic [15:0] a;
    logic        f;
  } bsw_row_t;
  bsw_row_t    rows [6] = '{'{4'h2, 4'h3, 16'h2000, 1'b1},
    '{4'h2, 4'h3, 16'h1FFF, 1'b0}, '{4'h2, 4'h3, 16'h3FFF, 1'b1},
    '{4'h2, 4'h3, 16'h4000, 1'b0}, '{4'h5, 4'h5, 16'h5ABC, 1'b1},
    '{4'h6, 4'h5, 16'h5800, 1'b0}};
  logic [15:0] fl [3] = '{16'h8000, 16'h2000, 16'h1000};
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, ack, fwd, own = 1'b0, gnt_req = 1'b0;
  logic        gnt, rel, irq, io_req = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [15:0] io_addr = 16'h0000;
  logic [31:0] wdat = 32'h0, rdat, q;
  bsw_evt_t    evt_req = '0, evt;
  int          bad_count = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  bsw_top dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .IO_ADDR_I(io_addr), .IO_REQ_I(io_req), .IO_FWD_O(fwd),
    .EVT_I(evt), .MST_OWN_I(own), .MST_GNT_I(gnt),
    .MST_RELEASE_O(rel), .IRQ_O(irq));
  bsw_gfx_model u_gfx (.clk_i(clk), .rst_n_i(rst_n), .evt_req_i(evt_req),
    .gnt_req_i(gnt_req), .evt_o(evt), .gnt_o(gnt));
  // ==========
  // checking and bus tasks
  task automatic results;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // holds the request until ack is sampled, then idles one cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    if (n >= 40) begin
      bad_count++;
      results();
    end else begin
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    wb(1'b0, a, 4'hF, 32'h0);
    chk("register", q & m, e);
  endtask
  task automatic bit_is(input string nm, input logic v, e);
    chk(nm, {31'h0, v}, {31'h0, e});
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bit_is("fwd", fwd, 1'b0);
    rd(8'h18, 32'hFF00_0000, 32'h0);
    rd(8'h1C, 32'hFFFF_FFFF, 32'h02A0_00F0);
    foreach (rows[i]) begin
      wb(1'b1, 8'h1C, 4'h3, {16'h0, rows[i].l, 4'hF, rows[i].b, 4'hF});
      io_addr <= rows[i].a;
      @(posedge clk);
      bit_is("fwd", fwd, rows[i].f);
      rd(8'h1C, 32'hFFFF, {16'h0, rows[i].l, 4'h0, rows[i].b, 4'h0});
    end
    // last access seen: 5800 outside the empty 6..5 window
    rd(8'h44, 32'h0001_FFFF, 32'h0000_5800);
    wb(1'b1, 8'h18, 4'h8, 32'hFFFF_FFFF);
    rd(8'h18, 32'hFF00_0000, 32'hF800_0000);
    wb(1'b1, 8'hFC, 4'hF, 32'hFFFF_FFFF);
    rd(8'hFC, 32'hFFFF_FFFF, 32'h0);
    // tenure: one count is eight clocks; grant held blocks release
    wb(1'b1, 8'h18, 4'h8, 32'h0800_0000);
    gnt_req <= 1'b1;
    own <= 1'b1;
    repeat (14) @(posedge clk);
    bit_is("release", rel, 1'b0);
    gnt_req <= 1'b0;
    repeat (3) @(posedge clk);
    bit_is("release", rel, 1'b1);
    own <= 1'b0;
    wb(1'b1, 8'h18, 4'h8, 32'h0);
    own <= 1'b1;
    repeat (30) @(posedge clk);
    bit_is("release", rel, 1'b0);
    own <= 1'b0;
    // events: masked first, then unmasked, each cleared by one
    for (int k = 0; k < 3; k++) begin
      evt_req <= bsw_evt_t'(3'b100 >> k);
      @(posedge clk);
      evt_req <= '0;
      repeat (2) @(posedge clk);
      bit_is("irq", irq, k != 0);
      wb(1'b1, 8'h40, 4'hC, 32'hB000_0000);
      bit_is("irq", irq, 1'b1);
      rd(8'h40, 32'hFFFF_FFFF, 32'hB000_0000);
      wb(1'b1, 8'h1C, 4'hC, 32'h0);
      rd(8'h1C, 32'hFFFF_0000, {fl[k] | 16'h02A0, 16'h0});
      wb(1'b1, 8'h1C, 4'hC, {fl[k], 16'h0});
      rd(8'h1C, 32'hFFFF_0000, 32'h02A0_0000);
      bit_is("irq", irq, 1'b0);
    end
    // second reset in mid-run brings the window back to its defaults
    wb(1'b1, 8'h1C, 4'h3, 32'h0000_1020);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h1C, 32'hFFFF_FFFF, 32'h02A0_00F0);
    rd(8'h40, 32'hFFFF_FFFF, 32'h0);
    bit_is("irq", irq, 1'b0);
    results();
  end
endmodule

// File: tb/bsw_gfx_model.sv
`timescale 1ns/1ps
// ==========
// secondary-bus graphics device: error events and grant
module bsw_gfx_model (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire bsw_pkg::bsw_evt_t evt_req_i,
  input  wire logic              gnt_req_i,
  output bsw_pkg::bsw_evt_t      evt_o,
  output logic                   gnt_o
);
  import bsw_pkg::*;
  // launched from a flop so edges never race the bench
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_o <= '0;
      gnt_o <= 1'b0;
    end else begin
      evt_o <= evt_req_i;
      gnt_o <= gnt_req_i;
    end
  end
endmodule

// File: tb/bsw_top_asserts.sv
`timescale 1ns/1ps
// ==========
// port checker
module bsw_top_asserts (
  input wire logic              CLK_SYS_I,
  input wire logic              RESET_N_I,
  input wire logic              WB_CYC_I,
  input wire logic              WB_STB_I,
  input wire logic              WB_WE_I,
  input wire logic [7:0]        WB_ADR_I,
  input wire logic [31:0]       WB_DAT_O,
  input wire logic              WB_ACK_O,
  input wire logic              IO_REQ_I,
  input wire logic              IO_FWD_O,
  input wire bsw_pkg::bsw_evt_t EVT_I,
  input wire logic              MST_OWN_I,
  input wire logic              MST_GNT_I,
  input wire logic              MST_RELEASE_O,
  input wire logic              IRQ_O
);
  import bsw_pkg::*;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  logic rd_st;
  logic rd_lt;
  logic wr;
  assign rd_st = WB_ACK_O && !WB_WE_I && WB_ADR_I[7:2] == 6'h07;
  assign rd_lt = WB_ACK_O && !WB_WE_I && WB_ADR_I[7:2] == 6'h06;
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
  fixed_bits_a: assert property (
    rd_st |-> (WB_DAT_O[31:16] & 16'h4FFF) == 16'h02A0)
    else $error("status fixed bits wrong");
  io_low_zero_a: assert property (
    rd_st |-> WB_DAT_O[3:0] == 4'h0 && WB_DAT_O[11:8] == 4'h0)
    else $error("io window low bits not zero");
  lat_low_zero_a: assert property (
    rd_lt |-> WB_DAT_O[26:24] == 3'h0) else $error("latency low bits set");
  fwd_req_a: assert property (
    IO_FWD_O |-> IO_REQ_I) else $error("forward without access");
  release_cond_a: assert property (
    MST_RELEASE_O |-> MST_OWN_I && !MST_GNT_I)
    else $error("release while granted or idle");
  release_wait_a: assert property (
    $rose(MST_OWN_I) |-> !MST_RELEASE_O [*7]) else $error("release early");
  irq_rise_a: assert property (
    $rose(IRQ_O) |-> $past(EVT_I != 3'h0) || $past(wr))
    else $error("irq without cause");
  irq_fall_a: assert property (
    $fell(IRQ_O) |-> $past(wr)) else $error("flag lost without write");
endmodule
bind bsw_top bsw_top_asserts u_chk (.CLK_SYS_I(CLK_SYS_I),
  .RESET_N_I(RESET_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .IO_REQ_I(IO_REQ_I), .IO_FWD_O(IO_FWD_O),
  .EVT_I(EVT_I), .MST_OWN_I(MST_OWN_I), .MST_GNT_I(MST_GNT_I),
  .MST_RELEASE_O(MST_RELEASE_O), .IRQ_O(IRQ_O));
